// [include/cam_bus_cmd_pkg.sv]
// Constants, types and codes for the camera control bus host command block.
// Assumes one APB clock; a separate serial engine drives the bus wires.
package cam_bus_cmd_pkg;

  // APB register map, byte addresses
  localparam int         PADDR_W    = 8;
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] LOCK_OFS   = 8'h08;
  localparam logic [7:0] SENSOR_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RATE_OFS   = 8'h14;
  localparam int         POOL_BIT   = 7;
  localparam int         POOL_BYTES = 128;
  localparam int         POOL_IDX_W = 7;
  localparam int         HEAD_BYTES = 6;

  // Lock and status register fields
  localparam int LOCK_REQ_BIT    = 0;
  localparam int LOCK_OWN_BIT    = 1;
  localparam int LOCK_PEND_BIT   = 2;
  localparam int STAT_ACTIVE_BIT = 8;
  localparam int STAT_RESP_BIT   = 9;

  // Command codes
  localparam logic [15:0] lock_release_cmd       = 16'h8d02;
  localparam logic [15:0] bus_config_cmd         = 16'h8d03;
  localparam logic [15:0] target_select_cmd      = 16'h8d04;
  localparam logic [15:0] bus_read_cmd           = 16'h8d05;
  localparam logic [15:0] bus_write_cmd          = 16'h8d06;
  localparam logic [15:0] masked_write_cmd       = 16'h8d07;
  localparam logic [15:0] transaction_status_cmd = 16'h8d08;

  // Result codes
  localparam logic [7:0] success_code          = 8'h00;
  localparam logic [7:0] no_response_code      = 8'h02;
  localparam logic [7:0] aborted_code          = 8'h05;
  localparam logic [7:0] access_denied_code    = 8'h0d;
  localparam logic [7:0] busy_code             = 8'h10;
  localparam logic [7:0] invalid_argument_code = 8'h16;
  localparam logic [7:0] out_of_range_code     = 8'h22;

  // Parameter byte offsets within the pool
  localparam int OFS_CFG     = 0;
  localparam int OFS_SELECT  = 0;
  localparam int OFS_REG_HI  = 0;
  localparam int OFS_REG_LO  = 1;
  localparam int OFS_LEN     = 2;
  localparam int OFS_BF_DATA = 2;
  localparam int OFS_BF_MASK = 4;
  localparam logic [POOL_IDX_W-1:0] OFS_WDATA = 7'h03;

  // Limits and reset values
  localparam logic [31:0] RATE_MIN_HZ     = 32'h000186a0;
  localparam logic [31:0] RATE_MAX_HZ     = 32'h00061a80;
  localparam logic [31:0] RATE_DEFAULT_HZ = 32'h00061a80;
  localparam logic [7:0]  LEN_MIN         = 8'h01;
  localparam logic [7:0]  READ_LEN_MAX    = 8'h7a;
  localparam logic [7:0]  WRITE_LEN_MAX   = 8'h77;
  localparam logic [7:0]  BF_LEN          = 8'h02;
  localparam logic [7:0]  SENSOR_ADDR_RST = 8'h20;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RD    = 5'b00010,
    ST_WR    = 5'b00100,
    ST_BF_RD = 5'b01000,
    ST_BF_WR = 5'b10000
  } txn_state_t;

endpackage

// [rtl/byte_store.sv]
// Byte array with a word port, a byte port and a fixed head view.
// Words are big-endian: the lowest byte offset sits in bits 31:24.
`timescale 1ns/1ns
module byte_store #(
  parameter int DEPTH = 128,
  parameter int HEAD  = 6
) (
  // Clock
  input  wire logic                       clk,
  // Word port
  input  wire logic [3:0]                 word_we,
  input  wire logic [$clog2(DEPTH)-3:0]   word_idx,
  input  wire logic [31:0]                word_wdata,
  output wire logic [31:0]                word_rdata,
  // Byte port
  input  wire logic                       byte_we,
  input  wire logic [$clog2(DEPTH)-1:0]   byte_idx,
  input  wire logic [7:0]                 byte_wdata,
  output wire logic [7:0]                 byte_rdata,
  // First bytes, offset 0 at the top
  output wire logic [8*HEAD-1:0]          head
);
  logic [7:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (word_we[i]) begin
        mem[{word_idx, 2'(3 - i)}] <= word_wdata[8*i +: 8];
      end
    end
    if (byte_we) begin
      mem[byte_idx] <= byte_wdata;
    end
  end

  assign word_rdata = {mem[{word_idx, 2'd0}], mem[{word_idx, 2'd1}],
                       mem[{word_idx, 2'd2}], mem[{word_idx, 2'd3}]};
  assign byte_rdata = mem[byte_idx];

  for (genvar g = 0; g < HEAD; g++) begin : g_head
    assign head[8*(HEAD-1-g) +: 8] = mem[g];
  end
endmodule

// [rtl/apb_access.sv]
// APB answer timing: one wait state, then registered data and error.
// Assumes the master holds its request until pready is seen high.
`timescale 1ns/1ns
module apb_access (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request
  input  wire logic        psel,
  input  wire logic        penable,
  // Answer source
  input  wire logic [31:0] rdata_in,
  input  wire logic        err_in,
  // Bus answer
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Completing edge of the access
  output wire logic        done
);
  // Wait state lets data come from a flop without a combinational path
  wire load = psel & penable & ~pready;

  assign done = psel & penable & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= load;
      prdata  <= load ? rdata_in : 32'h0000_0000;
      pslverr <= load & err_in;
    end
  end
endmodule

// [rtl/cam_bus_cmd.sv]
// Host command handler for the camera control bus, reached over APB.
// Assumes an external serial engine that takes a start pulse with
// target, address and length, and answers with byte and end strobes.
`timescale 1ns/1ns
module cam_bus_cmd
  import cam_bus_cmd_pkg::*;
#(
  parameter logic [7:0] SENSOR_ADDR_DEFAULT = SENSOR_ADDR_RST
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output wire logic [31:0]        prdata,
  output wire logic               pready,
  output wire logic               pslverr,
  // Access lock arbiter
  output logic                    lock_request,
  input  wire logic               lock_granted,
  // Serial engine
  output logic                    bus_start,
  output logic                    bus_read,
  output logic [6:0]              bus_target,
  output logic [15:0]             bus_reg_addr,
  output logic [7:0]              bus_len,
  output logic [7:0]              bus_wdata,
  output logic [31:0]             bus_rate_hz,
  input  wire logic [7:0]         bus_rdata,
  input  wire logic               bus_byte_done,
  input  wire logic               bus_done,
  input  wire logic               bus_nack,
  input  wire logic               bus_abort,
  // Transfer in flight
  output logic                    txn_active
);
  localparam int HEAD_W = 8 * HEAD_BYTES;

  function automatic logic [7:0] head_byte(input logic [HEAD_W-1:0] h, input int k);
    head_byte = h[HEAD_W-1-8*k -: 8];
  endfunction

  // State
  txn_state_t             state_r;
  txn_state_t             state_nxt;
  logic [POOL_IDX_W-1:0]  idx_r;
  logic [POOL_IDX_W-1:0]  idx_nxt;
  logic [15:0]            last_cmd_r;
  logic [7:0]             result_r;
  logic [7:0]             outcome_r;
  logic [7:0]             sensor_addr_r;
  logic [7:0]             target_r;
  logic                   last_read_r;
  logic                   resp_rd_r;
  logic [15:0]            bf_data_r;
  logic [15:0]            bf_mask_r;
  logic [15:0]            rd_val_r;
  logic [15:0]            rmw_val_r;
  logic                   txn_end;
  logic [7:0]             end_code;

  // APB decode
  logic                   apb_done;
  logic [31:0]            rd_mux;
  logic [31:0]            pool_word;
  logic [31:0]            rbuf_word;
  logic [7:0]             pool_byte;
  logic [HEAD_W-1:0]      head;

  wire aligned    = (paddr[1:0] == 2'b00);
  wire hit_pool   = aligned & paddr[POOL_BIT];
  wire hit_cmd    = aligned & (paddr == CMD_OFS);
  wire hit_result = aligned & (paddr == RESULT_OFS);
  wire hit_lock   = aligned & (paddr == LOCK_OFS);
  wire hit_sensor = aligned & (paddr == SENSOR_OFS);
  wire hit_status = aligned & (paddr == STATUS_OFS);
  wire hit_rate   = aligned & (paddr == RATE_OFS);
  wire hit_any    = hit_pool | hit_cmd | hit_result | hit_lock | hit_sensor
                  | hit_status | hit_rate;
  wire wr_done    = apb_done & pwrite & hit_any;
  wire pool_wr    = wr_done & hit_pool;
  wire cmd_wr     = wr_done & hit_cmd;
  wire [15:0] code = pwdata[15:0];

  // Lock ownership
  wire lock_owned   = lock_request & lock_granted;
  wire lock_pending = lock_request & ~lock_granted;

  // Command decode
  wire is_rel = (code == lock_release_cmd);
  wire is_cfg = (code == bus_config_cmd);
  wire is_sel = (code == target_select_cmd);
  wire is_rd  = (code == bus_read_cmd);
  wire is_wr  = (code == bus_write_cmd);
  wire is_bf  = (code == masked_write_cmd);
  wire is_st  = (code == transaction_status_cmd);
  wire gated  = is_cfg | is_sel | is_rd | is_wr | is_bf | is_st;
  wire busy_now = (state_r != ST_IDLE);

  // Parameters taken straight from the pool head
  wire [31:0] cfg_rate  = {head_byte(head, OFS_CFG), head_byte(head, OFS_CFG + 1),
                           head_byte(head, OFS_CFG + 2), head_byte(head, OFS_CFG + 3)};
  wire        cfg_ok    = (cfg_rate >= RATE_MIN_HZ) && (cfg_rate <= RATE_MAX_HZ);
  wire [7:0]  sel_byte  = head_byte(head, OFS_SELECT);
  wire [7:0]  sel_addr  = (sel_byte == 8'h00) ? sensor_addr_r : sel_byte;
  wire [15:0] reg_addr  = {head_byte(head, OFS_REG_HI), head_byte(head, OFS_REG_LO)};
  wire [7:0]  len_byte  = head_byte(head, OFS_LEN);
  wire        rd_len_ok = (len_byte >= LEN_MIN) && (len_byte <= READ_LEN_MAX);
  wire        wr_len_ok = (len_byte >= LEN_MIN) && (len_byte <= WRITE_LEN_MAX);
  wire        len_ok    = is_rd ? rd_len_ok : wr_len_ok;

  // Result of the command written this cycle
  wire [7:0] cmd_result =
      is_rel            ? (lock_pending ? busy_code : success_code) :
      (gated & ~lock_owned) ? access_denied_code :
      is_cfg            ? (cfg_ok ? success_code : invalid_argument_code) :
      is_sel            ? (busy_now ? busy_code : success_code) :
      (is_rd | is_wr)   ? (!len_ok ? out_of_range_code :
                           busy_now ? busy_code : success_code) :
      is_bf             ? (busy_now ? busy_code : success_code) :
      is_st             ? (busy_now ? busy_code : outcome_r) :
                          invalid_argument_code;

  wire ok_cmd    = cmd_wr & lock_owned & ~busy_now;
  wire accept    = ok_cmd & (((is_rd | is_wr) & len_ok) | is_bf);
  wire cfg_apply = cmd_wr & is_cfg & lock_owned & cfg_ok;
  wire sel_apply = ok_cmd & is_sel;
  wire rel_apply = cmd_wr & is_rel & ~lock_pending;
  wire show_read = ok_cmd & is_st & last_read_r & (outcome_r == success_code);

  // Transfer sequencing
  wire        bf_restart = (state_r == ST_BF_RD) && (state_nxt == ST_BF_WR);
  wire [15:0] rd_val_in  = bus_byte_done ? {rd_val_r[7:0], bus_rdata} : rd_val_r;
  wire [15:0] rmw_nxt    = bf_restart ? ((rd_val_in & ~bf_mask_r) | bf_data_r)
                                      : rmw_val_r;
  wire [POOL_IDX_W-1:0] wbyte_idx = OFS_WDATA + idx_nxt;
  wire [7:0]  wdata_nxt  = (state_nxt != ST_BF_WR) ? pool_byte :
                           (idx_nxt == '0) ? rmw_nxt[15:8] : rmw_nxt[7:0];
  wire        rbuf_we    = (state_r == ST_RD) & bus_byte_done;

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    txn_end   = 1'b0;
    end_code  = success_code;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = is_rd ? ST_RD : (is_wr ? ST_WR : ST_BF_RD);
          idx_nxt   = '0;
        end
      end
      ST_RD, ST_WR, ST_BF_RD, ST_BF_WR: begin
        if (bus_byte_done) begin
          idx_nxt = idx_r + 7'h01;
        end
        if (bus_nack | bus_abort | bus_done) begin
          state_nxt = ST_IDLE;
          txn_end   = 1'b1;
          if (bus_nack) begin
            end_code = no_response_code;
          end else if (bus_abort) begin
            end_code = aborted_code;
          end else if (state_r == ST_BF_RD) begin
            // Read half done: the write half reuses the same address
            state_nxt = ST_BF_WR;
            idx_nxt   = '0;
            txn_end   = 1'b0;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_IDLE;
      idx_r      <= '0;
      txn_active <= 1'b0;
      bus_start  <= 1'b0;
      bus_wdata  <= 8'h00;
      rd_val_r   <= 16'h0000;
      rmw_val_r  <= 16'h0000;
      outcome_r  <= success_code;
    end else begin
      state_r    <= state_nxt;
      idx_r      <= idx_nxt;
      txn_active <= (state_nxt != ST_IDLE);
      bus_start  <= accept | bf_restart;
      bus_wdata  <= wdata_nxt;
      rd_val_r   <= (state_r == ST_BF_RD) ? rd_val_in : rd_val_r;
      rmw_val_r  <= rmw_nxt;
      outcome_r  <= txn_end ? end_code : outcome_r;
    end
  end

  // Request fields held for the engine until the next acceptance; bus_read also drops when the masked write half starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_read     <= 1'b0;
      bus_reg_addr <= 16'h0000;
      bus_len      <= 8'h00;
      bf_data_r    <= 16'h0000;
      bf_mask_r    <= 16'h0000;
      last_read_r  <= 1'b0;
    end else if (accept) begin
      bus_read     <= is_rd | is_bf;
      bus_reg_addr <= reg_addr;
      bus_len      <= is_bf ? BF_LEN : len_byte;
      bf_data_r    <= {head_byte(head, OFS_BF_DATA), head_byte(head, OFS_BF_DATA + 1)};
      bf_mask_r    <= {head_byte(head, OFS_BF_MASK), head_byte(head, OFS_BF_MASK + 1)};
      last_read_r  <= is_rd;
    end else if (bf_restart) begin
      bus_read     <= 1'b0;
    end
  end

  // Configuration, target and lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rate_hz   <= RATE_DEFAULT_HZ;
      target_r      <= SENSOR_ADDR_DEFAULT;
      bus_target    <= SENSOR_ADDR_DEFAULT[7:1];
      sensor_addr_r <= SENSOR_ADDR_DEFAULT;
      lock_request  <= 1'b0;
    end else begin
      bus_rate_hz   <= cfg_apply ? cfg_rate : bus_rate_hz;
      target_r      <= sel_apply ? sel_addr : target_r;
      bus_target    <= sel_apply ? sel_addr[7:1] : bus_target;
      sensor_addr_r <= (wr_done & hit_sensor) ? pwdata[7:0] : sensor_addr_r;
      // A grant request from software sets it; only the release clears it
      lock_request  <= rel_apply ? 1'b0 :
                       (wr_done & hit_lock & pwdata[LOCK_REQ_BIT]) ? 1'b1 : lock_request;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmd_r <= 16'h0000;
      result_r   <= success_code;
      resp_rd_r  <= 1'b0;
    end else begin
      last_cmd_r <= cmd_wr ? code : last_cmd_r;
      result_r   <= cmd_wr ? cmd_result : result_r;
      // Pool shows read bytes until the host writes the pool or another transfer is accepted
      resp_rd_r  <= show_read | (resp_rd_r & ~pool_wr & ~accept);
    end
  end

  // Register read mux
  assign rd_mux =
      hit_pool   ? (resp_rd_r ? rbuf_word : pool_word) :
      hit_cmd    ? {16'h0000, last_cmd_r} :
      hit_result ? {24'h000000, result_r} :
      hit_lock   ? {29'h00000000, lock_pending, lock_owned, lock_request} :
      hit_sensor ? {24'h000000, sensor_addr_r} :
      hit_status ? {22'h000000, resp_rd_r, txn_active, target_r} :
      hit_rate   ? bus_rate_hz : 32'h0000_0000;

  apb_access u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .rdata_in (rd_mux),
    .err_in   (~hit_any),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .done     (apb_done)
  );

  byte_store #(.DEPTH(POOL_BYTES), .HEAD(HEAD_BYTES)) u_pool (
    .clk        (pclk),
    .word_we    ({4{pool_wr}}),
    .word_idx   (paddr[POOL_BIT-1:2]),
    .word_wdata (pwdata),
    .word_rdata (pool_word),
    .byte_we    (1'b0),
    .byte_idx   (wbyte_idx),
    .byte_wdata (8'h00),
    .byte_rdata (pool_byte),
    .head       (head)
  );

  byte_store #(.DEPTH(POOL_BYTES), .HEAD(HEAD_BYTES)) u_rbuf (
    .clk        (pclk),
    .word_we    (4'h0),
    .word_idx   (paddr[POOL_BIT-1:2]),
    .word_wdata (32'h0000_0000),
    .word_rdata (rbuf_word),
    .byte_we    (rbuf_we),
    .byte_idx   (idx_r),
    .byte_wdata (bus_rdata),
    .byte_rdata (),
    .head       ()
  );

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_release_busy: assert property (cmd_wr && is_rel && lock_pending
    |=> result_r == busy_code && lock_request)
    else $error("release while pending did not answer busy");
  a_release_done: assert property (cmd_wr && is_rel && !lock_pending
    |=> result_r == success_code && !lock_request)
    else $error("release did not drop the lock");
  a_cfg_reject: assert property (cmd_wr && is_cfg && lock_owned && !cfg_ok
    |=> result_r == invalid_argument_code && $stable(bus_rate_hz))
    else $error("bad bus speed was not rejected");
  a_no_lock_deny: assert property (cmd_wr && gated && !lock_owned
    |=> result_r == access_denied_code && !bus_start)
    else $error("command without lock was not denied");
  a_sel_sensor: assert property (sel_apply && sel_byte == 8'h00
    |=> target_r == sensor_addr_r && bus_target == sensor_addr_r[7:1])
    else $error("zero select did not pick the sensor address");
  // Refused request must leave the fields of the running transfer alone
  a_busy_single: assert property (cmd_wr && (is_rd || is_wr || is_bf) && busy_now
    && lock_owned && len_ok |=> result_r == busy_code && $stable(bus_reg_addr)
    && $stable(bus_len))
    else $error("second transfer was not refused");
  a_len_range: assert property (cmd_wr && is_rd && lock_owned && !rd_len_ok
    |=> result_r == out_of_range_code && !$rose(txn_active))
    else $error("bad read length was not refused");
  a_start_accept: assert property (accept |=> bus_start && txn_active
    ##1 !bus_start)
    else $error("accepted transfer did not start with one pulse");
  a_rmw_write: assert property (state_r == ST_BF_RD && bus_done && !bus_nack
    && !bus_abort |=> bus_start && !bus_read && bus_len == BF_LEN
    && bus_wdata == rmw_val_r[15:8])
    else $error("masked write did not start its write half");
  a_status_busy: assert property (cmd_wr && is_st && lock_owned && busy_now
    |=> result_r == busy_code)
    else $error("status while running did not answer busy");

  c_read_done: cover property (state_r == ST_RD && bus_done);
  c_masked_done: cover property (state_r == ST_BF_WR && bus_done);
  c_show_read: cover property (show_read);
  c_cfg_applied: cover property (cfg_apply);
endmodule

// [test/bus_engine_model.sv]
// Lock arbiter and serial engine stand-in for the command block.
// Assumes pclk sampling; a transfer ends in nack when nack_mode is set.
`timescale 1ns/1ns
module bus_engine_model (
  // Clock
  input  wire logic       pclk,
  // Block side
  input  wire logic       lock_request,
  input  wire logic       bus_start,
  input  wire logic       bus_read,
  input  wire logic [7:0] bus_len,
  input  wire logic [7:0] bus_wdata,
  output logic            lock_granted,
  output logic [7:0]      bus_rdata,
  output logic            bus_byte_done,
  output logic            bus_done,
  output logic            bus_nack,
  // Bench control
  input  wire logic       nack_mode
);
  logic [5:0] grant_r = 6'h00;
  logic [7:0] wbuf [0:3];
  int         i;
  // Slow grant so a pending lock can be seen
  assign lock_granted = grant_r[5];
  always @(posedge pclk) grant_r <= {grant_r[4:0], lock_request};
  initial begin
    bus_byte_done = 1'b0; bus_done = 1'b0; bus_nack = 1'b0; bus_rdata = 8'h00;
    forever begin
      @(posedge pclk);
      if (bus_start === 1'b1) begin
        repeat (40) @(posedge pclk);
        for (i = 0; i < bus_len; i++) begin
          bus_rdata <= 8'ha0 + i[7:0];
          bus_byte_done <= 1'b1;
          if (!bus_read) wbuf[i[1:0]] = bus_wdata;
          @(posedge pclk);
          bus_byte_done <= 1'b0;
          // Released data line shows the inverse, not a stale byte
          bus_rdata <= ~(8'ha0 + i[7:0]);
          // Gap cycle lets the block load its next write byte
          @(posedge pclk);
        end
        bus_nack <= nack_mode;
        bus_done <= !nack_mode;
        @(posedge pclk);
        bus_nack <= 1'b0;
        bus_done <= 1'b0;
      end
    end
  end
endmodule

// [test/cam_bus_cmd_tb.sv]
// Self-checking bench: APB command sequences against the engine model.
// Assumes the model above on the engine side; abort input held low except for one pulse.
`timescale 1ns/1ns
module cam_bus_cmd_tb
  import cam_bus_cmd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, nack_mode;
  logic [7:0] paddr, bus_rdata, bus_len, bus_wdata;
  logic [31:0] pwdata, prdata, bus_rate_hz;
  logic lock_request, lock_granted, bus_start, bus_read, bus_byte_done, bus_done, bus_nack;
  logic bus_abort, txn_active;
  logic [6:0] bus_target;
  logic [15:0] bus_reg_addr;
  logic [15:0] gated [6] = '{bus_config_cmd, target_select_cmd, bus_read_cmd,
                             bus_write_cmd, masked_write_cmd, transaction_status_cmd};
  int bad_count = 0, n_tests = 0;
  cam_bus_cmd cam_bus_cmd_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lock_request(lock_request), .lock_granted(lock_granted),
    .bus_start(bus_start), .bus_read(bus_read), .bus_target(bus_target),
    .bus_reg_addr(bus_reg_addr), .bus_len(bus_len), .bus_wdata(bus_wdata),
    .bus_rate_hz(bus_rate_hz), .bus_rdata(bus_rdata), .bus_byte_done(bus_byte_done),
    .bus_done(bus_done), .bus_nack(bus_nack), .bus_abort(bus_abort), .txn_active(txn_active));
  bus_engine_model bus_engine_model_inst (.pclk(pclk), .lock_request(lock_request),
    .bus_start(bus_start), .bus_read(bus_read), .bus_len(bus_len), .bus_wdata(bus_wdata),
    .lock_granted(lock_granted), .bus_rdata(bus_rdata), .bus_byte_done(bus_byte_done),
    .bus_done(bus_done), .bus_nack(bus_nack), .nack_mode(nack_mode));
  always #20 pclk = ~pclk;
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge pclk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin bad_count++; results(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, r);
    chk(nm, e & m, r & m);
  endtask
  task automatic cmd(input logic [15:0] c, input logic [7:0] e);
    wr(CMD_OFS, {16'h0, c});
    rd("result", RESULT_OFS, {24'h0, e}, 32'hff);
  endtask
  task automatic idle_wait();
    int k;
    k = 0;
    while (txn_active !== 1'b0 && k < 400) begin @(posedge pclk); k++; end
    if (k >= 400) begin bad_count++; results(); end
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; nack_mode = 0; bus_abort = 0; perr = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("rate", RATE_OFS, RATE_DEFAULT_HZ, 32'hffffffff);
    foreach (gated[i]) cmd(gated[i], access_denied_code);
    wr(LOCK_OFS, 32'h1);
    cmd(lock_release_cmd, busy_code);
    for (int k = 0; k < 50 && lock_granted !== 1'b1; k++) @(posedge pclk);
    rd("lock", LOCK_OFS, 32'h3, 32'h7);
    // Config limits, both edges of the window
    wr(8'h80, 32'h0001869f); cmd(bus_config_cmd, invalid_argument_code);
    wr(8'h80, 32'h00061a81); cmd(bus_config_cmd, invalid_argument_code);
    wr(8'h80, RATE_MIN_HZ); cmd(bus_config_cmd, success_code);
    rd("rate", RATE_OFS, RATE_MIN_HZ, 32'hffffffff);
    wr(SENSOR_OFS, 32'h42); wr(8'h80, 32'h0); cmd(target_select_cmd, success_code);
    chk("target", 32'h21, {25'h0, bus_target});
    wr(8'h80, 32'h6c00_0000); cmd(target_select_cmd, success_code);
    chk("target", 32'h36, {25'h0, bus_target});
    wr(8'h80, 32'h1234_0000); cmd(bus_read_cmd, out_of_range_code);
    wr(8'h80, 32'h1234_7b00); cmd(bus_read_cmd, out_of_range_code);
    wr(8'h80, 32'h1234_7800); cmd(bus_write_cmd, out_of_range_code);
    wr(8'h80, 32'h1234_0300); cmd(bus_read_cmd, success_code);
    chk("raddr", {8'h1, 8'h3, 16'h1234}, {8'h1, bus_len, bus_reg_addr});
    chk("dir", 32'h1, {31'h0, bus_read});
    cmd(target_select_cmd, busy_code);
    cmd(bus_read_cmd, busy_code);
    cmd(transaction_status_cmd, busy_code);
    idle_wait();
    chk("target", 32'h36, {25'h0, bus_target});
    cmd(transaction_status_cmd, success_code);
    rd("rbytes", 8'h80, 32'ha0a1a200, 32'hffffff00);
    wr(8'h80, 32'h0456_025a); wr(8'h84, 32'hc300_0000);
    cmd(bus_write_cmd, success_code);
    idle_wait();
    cmd(transaction_status_cmd, success_code);
    chk("wbytes", 32'h5ac3, {bus_engine_model_inst.wbuf[0], bus_engine_model_inst.wbuf[1]});
    wr(8'h80, 32'h0789_000f); wr(8'h84, 32'h00f0_0000);
    cmd(masked_write_cmd, success_code);
    idle_wait();
    chk("rmw", 32'ha00f, {bus_engine_model_inst.wbuf[0], bus_engine_model_inst.wbuf[1]});
    chk("rmwaddr", 32'h0789, {16'h0, bus_reg_addr});
    nack_mode <= 1'b1;
    wr(8'h80, 32'h0100_0100); cmd(bus_read_cmd, success_code);
    idle_wait();
    cmd(transaction_status_cmd, no_response_code);
    nack_mode <= 1'b0;
    // Abort from the engine side while the model is still waiting
    wr(8'h80, 32'h0100_0100); cmd(bus_read_cmd, success_code);
    bus_abort <= 1'b1;
    @(posedge pclk);
    bus_abort <= 1'b0;
    idle_wait();
    cmd(transaction_status_cmd, aborted_code);
    rd("unmapped", 8'h40, 32'h0, 32'hffffffff);
    chk("pslverr", 32'h1, {31'h0, perr});
    cmd(16'h8d09, invalid_argument_code);
    cmd(lock_release_cmd, success_code);
    cmd(bus_config_cmd, access_denied_code);
    results();
  end
endmodule
